// *** core/ext_ctrl_defines.svh ***
`ifndef EXT_CTRL_DEFINES_SVH
`define EXT_CTRL_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADDR_W           5
`define OFS_ASSIGN       5'h00
`define OFS_OUTSEL       5'h04
`define OFS_STATUS       5'h08
`define OFS_IRQ_STAT     5'h0C
`define OFS_IRQ_MASK     5'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASSIGN_W         9
`define ACT_W            3
`define OUTSEL_W         4
`define SEL_W            2
`define OUTSEL_PASS_LSB  0
`define OUTSEL_FAIL_LSB  2
`define STAT_MEAS_BIT    0
`define STAT_LVL_LSB     1
`define STAT_IGN_BIT     4
`define STAT_PIN_LSB     5
`define IRQ_W            5
`define IRQ_START_BIT    0
`define IRQ_STOP_BIT     1
`define IRQ_ABORT_BIT    2
`define IRQ_SAVE_BIT     3
`define IRQ_EVENT_BIT    4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ASSIGN_RST       9'h088
`define OUTSEL_RST       4'h0
`define IRQ_MASK_RST     5'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ           20000000
`define RESP_MS          30
`define RESP_CYCLES      ((`RESP_MS * `CLK_HZ + 999) / 1000)

`endif

// *** core/ext_ctrl_pkg.sv ***
package ext_ctrl_pkg;

	// ----------------------------------------
	// Input actions
	// ----------------------------------------
	typedef enum logic [2:0] {
		ACT_START     = 3'b000,
		ACT_STOP      = 3'b001,
		ACT_LEVEL_RUN = 3'b010,
		ACT_ABORT     = 3'b011,
		ACT_SAVE      = 3'b100,
		ACT_EVENT     = 3'b101
	} action_t;

	// ----------------------------------------
	// Status output conditions
	// ----------------------------------------
	typedef enum logic [1:0] {
		COND_JUDGE     = 2'b00,
		COND_ERROR     = 2'b01,
		COND_BUSY      = 2'b10,
		COND_WAIT_TRIG = 2'b11
	} cond_sel_t;

	typedef enum logic {
		MEAS_IDLE = 1'b0,
		MEAS_RUN  = 1'b1
	} meas_state_t;

endpackage

// *** core/input_conditioner.sv ***
`timescale 1ns/1ps
`default_nettype none

module input_conditioner import ext_ctrl_pkg::*; #(
	parameter int unsigned STABLE_CYCLES = 600000
) (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic resetn_i,
	// Pin
	input  wire logic pin_i,
	// Conditioned level and edges
	output logic      level_o,
	output logic      fall_o,
	output logic      rise_o
);

	localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);

	logic          sync_a;
	logic          sync_b;
	logic [CW-1:0] count;

	wire differs = (sync_b != level_o);
	wire settled = (count == CW'(STABLE_CYCLES - 1));

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end else begin
			sync_a <= pin_i;
			sync_b <= sync_a;
		end
	end

	// Level taken only after a full stable interval
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count   <= '0;
			level_o <= 1'b1;
			fall_o  <= 1'b0;
			rise_o  <= 1'b0;
		end else begin
			fall_o <= 1'b0;
			rise_o <= 1'b0;
			if (!differs) begin
				count <= '0;
			end else if (settled) begin
				count   <= '0;
				level_o <= sync_b;
				fall_o  <= ~sync_b;
				rise_o  <= sync_b;
			end else begin
				count <= count + CW'(1);
			end
		end
	end

endmodule

`default_nettype wire

// *** core/status_driver.sv ***
`timescale 1ns/1ps
`default_nettype none

module status_driver import ext_ctrl_pkg::*; (
	// Clock and reset
	input  wire logic      sys_clk_i,
	input  wire logic      resetn_i,
	// Selection and conditions
	input  wire cond_sel_t sel_i,
	input  wire logic      judge_i,
	input  wire logic      error_i,
	input  wire logic      busy_i,
	input  wire logic      wait_trig_i,
	// Open-drain pin
	input  wire logic      pin_i,
	output logic           pin_o,
	output logic           pin_oe_o,
	output logic           pin_level_o
);

	logic pin_sync;

	wire active = (sel_i == COND_JUDGE) ? judge_i :
	              (sel_i == COND_ERROR) ? error_i :
	              (sel_i == COND_BUSY)  ? busy_i  : wait_trig_i;

	// Pulls low only while the condition holds
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_o    <= 1'b0;
			pin_oe_o <= 1'b0;
		end else begin
			pin_o    <= 1'b0;
			pin_oe_o <= active;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_sync    <= 1'b1;
			pin_level_o <= 1'b1;
		end else begin
			pin_sync    <= pin_i;
			pin_level_o <= pin_sync;
		end
	end

endmodule

`default_nettype wire

// *** core/ext_control.sv ***
// Behaviour
// - After reset input a starts, input b stops and input c runs on its level.
// - An input set to start begins a measurement when it is asserted.
// - An input set to stop ends the measurement and requests post-processing.
// - An input set to level run measures while low and stops when it goes high.
// - An input set to abort ends the measurement at once with no post-processing.
// - On abort the final sample may be left unrecorded.
// - An input set to save requests a save with the front-panel save settings.
// - An input set to event inserts an event mark each time it is asserted while a measurement runs.
// - Inputs are ignored during help, manual save, self-check and calibration.
// - The key lock does not gate the external inputs.
// - Each status output rests high and is pulled low only while its condition holds.
// - Each status output selects judgment, error, busy or waiting for trigger.

`timescale 1ns/1ps
`default_nettype none

`include "ext_ctrl_defines.svh"

module ext_control import ext_ctrl_pkg::*; #(
	parameter int unsigned STABLE_CYCLES = `RESP_CYCLES
) (
	// Clock and reset
	input  wire logic               sys_clk_i,
	input  wire logic               resetn_i,
	// Avalon-MM slave
	input  wire logic [`ADDR_W-1:0] avs_address_i,
	input  wire logic               avs_read_i,
	input  wire logic               avs_write_i,
	input  wire logic [31:0]        avs_writedata_i,
	input  wire logic [3:0]         avs_byteenable_i,
	output logic      [31:0]        avs_readdata_o,
	output logic                    avs_waitrequest_o,
	output logic                    irq_o,
	// External inputs
	input  wire logic               ext_input_a_i,
	input  wire logic               ext_input_b_i,
	input  wire logic               ext_input_c_i,
	// Status outputs
	input  wire logic               pass_status_output_i,
	output logic                    pass_status_output_o,
	output logic                    pass_status_output_oe_o,
	input  wire logic               fail_status_output_i,
	output logic                    fail_status_output_o,
	output logic                    fail_status_output_oe_o,
	// Instrument state
	input  wire logic               help_screen_i,
	input  wire logic               manual_save_win_i,
	input  wire logic               self_check_i,
	input  wire logic               touch_cal_i,
	input  wire logic               judge_pass_i,
	input  wire logic               judge_fail_i,
	input  wire logic               error_i,
	input  wire logic               busy_i,
	input  wire logic               wait_trig_i,
	// Measurement control
	output logic                    measuring_o,
	output logic                    meas_start_o,
	output logic                    meas_stop_o,
	output logic                    post_process_o,
	output logic                    meas_abort_o,
	output logic                    skip_last_sample_o,
	output logic                    save_request_o,
	output logic                    event_mark_o
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Action vector: {event, save, abort, stop, start}
	function automatic logic [4:0] action_fire(
		input logic [`ACT_W-1:0] act,
		input logic              fall,
		input logic              rise
	);
		logic [4:0] f;
		f = 5'h00;
		unique case (act)
			ACT_START:     f[0] = fall;
			ACT_STOP:      f[1] = fall;
			ACT_LEVEL_RUN: begin
				f[0] = fall;
				f[1] = rise;
			end
			ACT_ABORT:     f[2] = fall;
			ACT_SAVE:      f[3] = fall;
			ACT_EVENT:     f[4] = fall;
			default:       f = 5'h00;
		endcase
		return f;
	endfunction

	function automatic logic [31:0] merge_be(
		input logic [31:0] old,
		input logic [31:0] wdata,
		input logic [3:0]  be
	);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[8*i +: 8] = wdata[8*i +: 8];
			end
		end
		return m;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [`ASSIGN_W-1:0] assign_reg;
	logic [`OUTSEL_W-1:0] outsel;
	logic [`IRQ_W-1:0]    irq_stat;
	logic [`IRQ_W-1:0]    irq_mask;
	meas_state_t          state;
	meas_state_t          next_state;

	// ----------------------------------------
	// Input conditioning
	// ----------------------------------------
	wire [2:0] pins = {ext_input_c_i, ext_input_b_i, ext_input_a_i};
	wire [2:0] lvl;
	wire [2:0] fall;
	wire [2:0] rise;

	for (genvar k = 0; k < 3; k++) begin : g_in
		input_conditioner #(
			.STABLE_CYCLES (STABLE_CYCLES)
		) u_cond (
			.sys_clk_i (sys_clk_i),
			.resetn_i  (resetn_i),
			.pin_i     (pins[k]),
			.level_o   (lvl[k]),
			.fall_o    (fall[k]),
			.rise_o    (rise[k])
		);
	end

	// ----------------------------------------
	// Action decode
	// ----------------------------------------
	// Key lock has no say in this gating
	wire       ignore = help_screen_i | manual_save_win_i |
	                    self_check_i | touch_cal_i;
	wire [4:0] fire_a = action_fire(assign_reg[2:0], fall[0], rise[0]);
	wire [4:0] fire_b = action_fire(assign_reg[5:3], fall[1], rise[1]);
	wire [4:0] fire_c = action_fire(assign_reg[8:6], fall[2], rise[2]);
	wire [4:0] fire   = ignore ? 5'h00 : (fire_a | fire_b | fire_c);

	wire running   = (state == MEAS_RUN);
	wire do_abort  = running & fire[2];
	wire do_stop   = running & fire[1] & ~fire[2];
	wire do_start  = ~running & fire[0] & ~fire[1] & ~fire[2];
	wire do_save   = fire[3];
	wire do_event  = running & fire[4];

	wire [`IRQ_W-1:0] irq_ev = {do_event, do_save, do_abort, do_stop, do_start};

	// ----------------------------------------
	// Measurement state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			MEAS_IDLE: begin
				if (do_start) begin
					next_state = MEAS_RUN;
				end
			end
			MEAS_RUN: begin
				if (do_abort || do_stop) begin
					next_state = MEAS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= MEAS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			measuring_o        <= 1'b0;
			meas_start_o       <= 1'b0;
			meas_stop_o        <= 1'b0;
			post_process_o     <= 1'b0;
			meas_abort_o       <= 1'b0;
			skip_last_sample_o <= 1'b0;
			save_request_o     <= 1'b0;
			event_mark_o       <= 1'b0;
		end else begin
			measuring_o        <= (next_state == MEAS_RUN);
			meas_start_o       <= do_start;
			meas_stop_o        <= do_stop;
			post_process_o     <= do_stop;
			meas_abort_o       <= do_abort;
			skip_last_sample_o <= do_abort;
			save_request_o     <= do_save;
			event_mark_o       <= do_event;
		end
	end

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	wire pass_pin_lvl;
	wire fail_pin_lvl;

	status_driver u_pass (
		.sys_clk_i   (sys_clk_i),
		.resetn_i    (resetn_i),
		.sel_i       (cond_sel_t'(outsel[`OUTSEL_PASS_LSB +: `SEL_W])),
		.judge_i     (judge_pass_i),
		.error_i     (error_i),
		.busy_i      (busy_i),
		.wait_trig_i (wait_trig_i),
		.pin_i       (pass_status_output_i),
		.pin_o       (pass_status_output_o),
		.pin_oe_o    (pass_status_output_oe_o),
		.pin_level_o (pass_pin_lvl)
	);

	status_driver u_fail (
		.sys_clk_i   (sys_clk_i),
		.resetn_i    (resetn_i),
		.sel_i       (cond_sel_t'(outsel[`OUTSEL_FAIL_LSB +: `SEL_W])),
		.judge_i     (judge_fail_i),
		.error_i     (error_i),
		.busy_i      (busy_i),
		.wait_trig_i (wait_trig_i),
		.pin_i       (fail_status_output_i),
		.pin_o       (fail_status_output_o),
		.pin_oe_o    (fail_status_output_oe_o),
		.pin_level_o (fail_pin_lvl)
	);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire accept   = (avs_read_i | avs_write_i) & avs_waitrequest_o;
	wire wr_en    = avs_write_i & ~avs_waitrequest_o;
	wire hit_asg  = (avs_address_i == `OFS_ASSIGN);
	wire hit_osel = (avs_address_i == `OFS_OUTSEL);
	wire hit_stat = (avs_address_i == `OFS_STATUS);
	wire hit_istat = (avs_address_i == `OFS_IRQ_STAT);
	wire hit_imask = (avs_address_i == `OFS_IRQ_MASK);

	wire [31:0] status_word = {25'h0000000, fail_pin_lvl, pass_pin_lvl,
	                           ignore, lvl, running};

	wire [31:0] rd_mux = hit_asg   ? {23'h000000, assign_reg} :
	                     hit_osel  ? {28'h0000000, outsel} :
	                     hit_stat  ? status_word :
	                     hit_istat ? {27'h0000000, irq_stat} :
	                     hit_imask ? {27'h0000000, irq_mask} : 32'h00000000;

	wire [31:0] wr_asg   = merge_be({23'h000000, assign_reg}, avs_writedata_i,
	                                avs_byteenable_i);
	wire [31:0] wr_osel  = merge_be({28'h0000000, outsel}, avs_writedata_i,
	                                avs_byteenable_i);
	wire [31:0] wr_imask = merge_be({27'h0000000, irq_mask}, avs_writedata_i,
	                                avs_byteenable_i);
	wire [`IRQ_W-1:0] irq_clr = (wr_en & hit_istat & avs_byteenable_i[0]) ?
	                            avs_writedata_i[`IRQ_W-1:0] : 5'h00;
	wire [`IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h00000000;
		end else begin
			avs_waitrequest_o <= ~accept;
			if (accept && avs_read_i) begin
				avs_readdata_o <= rd_mux;
			end
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			assign_reg <= `ASSIGN_RST;
			outsel     <= `OUTSEL_RST;
			irq_mask   <= `IRQ_MASK_RST;
		end else if (wr_en) begin
			if (hit_asg) begin
				assign_reg <= wr_asg[`ASSIGN_W-1:0];
			end
			if (hit_osel) begin
				outsel <= wr_osel[`OUTSEL_W-1:0];
			end
			if (hit_imask) begin
				irq_mask <= wr_imask[`IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_stat <= 5'h00;
			irq_o    <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq_o    <= |(next_irq_stat & irq_mask);
		end
	end

endmodule

`default_nettype wire

// *** verification/ext_control_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module ext_control_sva #(
	parameter int unsigned STABLE_CYCLES = 8
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Bus and pins
	input wire logic avs_waitrequest_o,
	input wire logic ext_input_a_i,
	input wire logic ext_input_b_i,
	input wire logic ext_input_c_i,
	// Instrument state
	input wire logic help_screen_i,
	input wire logic manual_save_win_i,
	input wire logic self_check_i,
	input wire logic touch_cal_i,
	input wire logic judge_pass_i,
	input wire logic judge_fail_i,
	input wire logic error_i,
	input wire logic busy_i,
	input wire logic wait_trig_i,
	// Outputs
	input wire logic pass_status_output_o,
	input wire logic pass_status_output_oe_o,
	input wire logic fail_status_output_o,
	input wire logic fail_status_output_oe_o,
	input wire logic measuring_o,
	input wire logic meas_start_o,
	input wire logic meas_stop_o,
	input wire logic post_process_o,
	input wire logic meas_abort_o,
	input wire logic skip_last_sample_o,
	input wire logic save_request_o,
	input wire logic event_mark_o
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic [2:0]  pins_q;
	int unsigned quiet;
	wire         ign = help_screen_i | manual_save_win_i | self_check_i | touch_cal_i;
	wire         any_act = meas_start_o | meas_stop_o | meas_abort_o | save_request_o
		| event_mark_o;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pins_q <= 3'h7;
			quiet  <= 0;
		end else if ({ext_input_c_i, ext_input_b_i, ext_input_a_i} != pins_q) begin
			pins_q <= {ext_input_c_i, ext_input_b_i, ext_input_a_i};
			quiet  <= 0;
		end else if (quiet < 1000) begin
			quiet <= quiet + 1;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_OD_VALUE: assert property (!pass_status_output_o && !fail_status_output_o)
		else $error("open-drain value not low");
	AST_PASS_CAUSE: assert property (pass_status_output_oe_o |->
		$past(judge_pass_i || error_i || busy_i || wait_trig_i)) else $error("pass low without cause");
	AST_FAIL_CAUSE: assert property (fail_status_output_oe_o |->
		$past(judge_fail_i || error_i || busy_i || wait_trig_i)) else $error("fail low without cause");
	AST_START_ONCE: assert property (meas_start_o |=> !meas_start_o)
		else $error("start pulse too long");
	AST_START_RUN: assert property (meas_start_o |-> ##[0:1] measuring_o)
		else $error("start did not run");
	AST_STOP_POST: assert property (meas_stop_o |-> ##[0:2] post_process_o)
		else $error("stop without post-processing");
	AST_ABORT: assert property (meas_abort_o |-> (skip_last_sample_o && !post_process_o)
		##1 (!measuring_o && !post_process_o)) else $error("abort misbehaved");
	AST_EVENT_RUN: assert property (event_mark_o |-> (measuring_o || $past(measuring_o)))
		else $error("event mark while idle");
	AST_IGNORE: assert property (ign [*3] |=> !any_act)
		else $error("action while ignoring");
	AST_STABLE: assert property (any_act |-> quiet >= STABLE_CYCLES)
		else $error("action before stable interval");
	AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");

	C_START: cover property (meas_start_o);
	C_ABORT: cover property (meas_abort_o);
	C_IGNORE: cover property (ign && quiet == 2);
endmodule

bind ext_control ext_control_sva #(.STABLE_CYCLES(STABLE_CYCLES)) u_sva (.sys_clk_i, .resetn_i,
	.avs_waitrequest_o, .ext_input_a_i, .ext_input_b_i, .ext_input_c_i, .help_screen_i,
	.manual_save_win_i, .self_check_i, .touch_cal_i, .judge_pass_i, .judge_fail_i, .error_i,
	.busy_i, .wait_trig_i, .pass_status_output_o, .pass_status_output_oe_o,
	.fail_status_output_o, .fail_status_output_oe_o, .measuring_o, .meas_start_o,
	.meas_stop_o, .post_process_o, .meas_abort_o, .skip_last_sample_o, .save_request_o,
	.event_mark_o);

`default_nettype wire

// *** verification/ext_equipment_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module ext_equipment_model #(
	parameter int unsigned HOLD = 16
) (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       resetn_i,
	// Requests and pins
	input  wire logic [2:0] want_i,
	input  wire logic       pass_oe_i,
	input  wire logic       fail_oe_i,
	output logic      [2:0] pins_o,
	output logic            pass_wire_o,
	output logic            fail_wire_o
);
	int unsigned held;

	// Each level is held at least HOLD cycles
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pins_o <= 3'h7;
			held   <= 0;
		end else if (want_i != pins_o && held >= HOLD) begin
			pins_o <= want_i;
			held   <= 0;
		end else if (held < HOLD) begin
			held <= held + 1;
		end
	end

	// Pull-ups on the open-drain lines
	assign pass_wire_o = pass_oe_i ? 1'b0 : 1'b1;
	assign fail_wire_o = fail_oe_i ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// *** verification/tb_external_control_terminals.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ext_ctrl_defines.svh"
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module tb_external_control_terminals import ext_ctrl_pkg::*; ;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [4:0]  addr = 5'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be = 4'hF;
	logic [31:0] rdata;
	logic        wait_req;
	logic        irq;
	logic [2:0]  want = 3'h7;
	logic [2:0]  pins;
	logic [3:0]  ign = 4'h0;
	logic [4:0]  cond = 5'h00;
	logic        pass_oe;
	logic        fail_oe;
	logic        pass_w;
	logic        fail_w;
	logic        meas;
	logic [6:0]  pulse;
	int          pc [7];
	int          err_count = 0;
	int          n_tests = 0;

	always #25 sys_clk = ~sys_clk;

	ext_control #(.STABLE_CYCLES(8)) dut (.sys_clk_i(sys_clk), .resetn_i(resetn),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
		.irq_o(irq), .ext_input_a_i(pins[0]), .ext_input_b_i(pins[1]), .ext_input_c_i(pins[2]),
		.pass_status_output_i(pass_w), .pass_status_output_o(), .pass_status_output_oe_o(pass_oe),
		.fail_status_output_i(fail_w), .fail_status_output_o(), .fail_status_output_oe_o(fail_oe),
		.help_screen_i(ign[0]), .manual_save_win_i(ign[1]), .self_check_i(ign[2]),
		.touch_cal_i(ign[3]), .judge_pass_i(cond[0]), .judge_fail_i(cond[1]), .error_i(cond[2]),
		.busy_i(cond[3]), .wait_trig_i(cond[4]), .measuring_o(meas), .meas_start_o(pulse[0]),
		.meas_stop_o(pulse[1]), .post_process_o(pulse[2]), .meas_abort_o(pulse[3]),
		.skip_last_sample_o(pulse[4]), .save_request_o(pulse[5]), .event_mark_o(pulse[6]));

	ext_equipment_model #(.HOLD(16)) partner (.sys_clk_i(sys_clk), .resetn_i(resetn),
		.want_i(want), .pass_oe_i(pass_oe), .fail_oe_i(fail_oe), .pins_o(pins),
		.pass_wire_o(pass_w), .fail_wire_o(fail_w));

	always @(posedge sys_clk) begin
		for (int i = 0; i < 7; i++) if (pulse[i] === 1'b1) pc[i]++;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge sys_clk);
		addr  <= a;
		wr    <= w;
		rd    <= !w;
		wdata <= d;
		@(posedge sys_clk);
		while (wait_req !== 1'b0) begin
			@(posedge sys_clk);
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic pin(input int i, input logic lvl);
		want[i] <= lvl;
		repeat (40) @(posedge sys_clk);
	endtask

	task automatic clr();
		for (int i = 0; i < 7; i++) pc[i] = 0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_defaults();
		logic [31:0] q;
		bus(1'b0, `OFS_ASSIGN, 32'h0, q);
		`CHECK(q, {23'h0, ACT_LEVEL_RUN, ACT_STOP, ACT_START})
		bus(1'b0, `OFS_OUTSEL, 32'h0, q);
		`CHECK(q, 32'h0)
		bus(1'b0, 5'h14, 32'h0, q);
		`CHECK(q, 32'h0)
		clr();
		pin(0, 1'b0);
		`CHECK(meas, 1'b1)
		repeat (40) @(posedge sys_clk);
		`CHECK(pc[0], 1)
		pin(0, 1'b1);
		pin(1, 1'b0);
		`CHECK(meas, 1'b0)
		`CHECK(pc[2], 1)
		pin(1, 1'b1);
		pin(2, 1'b0);
		`CHECK(meas, 1'b1)
		pin(2, 1'b1);
		`CHECK(meas, 1'b0)
		`CHECK(pc[1], 2)
		bus(1'b0, `OFS_IRQ_STAT, 32'h0, q);
		`CHECK(q, 32'h3)
		`CHECK(irq, 1'b0)
		bus(1'b1, `OFS_IRQ_MASK, 32'h1F, q);
		repeat (2) @(posedge sys_clk);
		`CHECK(irq, 1'b1)
		bus(1'b1, `OFS_IRQ_STAT, 32'h1F, q);
		repeat (2) @(posedge sys_clk);
		`CHECK(irq, 1'b0)
	endtask

	task automatic t_actions();
		logic [31:0] q;
		bus(1'b1, `OFS_ASSIGN, {23'h0, ACT_ABORT, ACT_EVENT, ACT_START}, q);
		clr();
		pin(0, 1'b0);
		pin(0, 1'b1);
		pin(1, 1'b0);
		pin(1, 1'b1);
		pin(1, 1'b0);
		`CHECK(pc[6], 2)
		pin(1, 1'b1);
		pin(2, 1'b0);
		`CHECK(pc[3], 1)
		`CHECK(pc[4], 1)
		`CHECK(pc[2], 0)
		`CHECK(meas, 1'b0)
		pin(2, 1'b1);
		bus(1'b1, `OFS_ASSIGN, {23'h0, ACT_ABORT, ACT_EVENT, ACT_SAVE}, q);
		pin(0, 1'b0);
		`CHECK(pc[5], 1)
		pin(0, 1'b1);
		bus(1'b0, `OFS_IRQ_STAT, 32'h0, q);
		`CHECK(q, 32'h1D)
		`CHECK(irq, 1'b1)
		for (int i = 0; i < 4; i++) begin
			ign <= 4'h1 << i;
			pin(0, 1'b0);
			pin(0, 1'b1);
		end
		ign <= 4'h0;
		`CHECK(pc[5], 1)
		pin(0, 1'b0);
		`CHECK(pc[5], 2)
		pin(0, 1'b1);
		resetn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		bus(1'b0, `OFS_ASSIGN, 32'h0, q);
		`CHECK(q, {23'h0, ACT_LEVEL_RUN, ACT_STOP, ACT_START})
	endtask

	task automatic t_outputs();
		logic [31:0] q;
		logic [4:0]  on;
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, `OFS_OUTSEL, {28'h0, 2'(s), 2'(s)}, q);
			on = (s == 0) ? 5'h03 : (5'h02 << s);
			cond <= on;
			repeat (3) @(posedge sys_clk);
			`CHECK({pass_w, fail_w}, 2'b00)
			cond <= ~on;
			repeat (3) @(posedge sys_clk);
			`CHECK({pass_w, fail_w}, 2'b11)
		end
		bus(1'b1, `OFS_OUTSEL, 32'h0, q);
		cond <= 5'h01;
		repeat (3) @(posedge sys_clk);
		`CHECK({pass_w, fail_w}, 2'b01)
		bus(1'b0, `OFS_STATUS, 32'h0, q);
		`CHECK(q, 32'h0000004E)
	endtask

	task automatic print_verdict();
		if (err_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		t_defaults();
		t_actions();
		t_outputs();
		print_verdict();
	end

	initial begin
		repeat (30000) @(posedge sys_clk);
		err_count++;
		print_verdict();
	end
endmodule

`default_nettype wire
